// file: hw/bzs_pkg.sv
// Package: constants and types for the back-EMF zero-cross sampler
package bzs_pkg;
  // Peripheral clock rate and delay step
  localparam int unsigned CLK_HZ          = 20_000_000;
  // Delay and blanking are counted in clock cycles, so they scale with
  // the clock; the times below hold at this reference rate
  localparam int unsigned REF_HZ          = 4_000_000;
  localparam int unsigned DELAY_STEP_NS   = 2500;   // 2.5 us per step
  localparam int unsigned DELAY_STEP_CYC  =
    (DELAY_STEP_NS * (REF_HZ / 1_000_000) + 999) / 1000;
  // Commutation blanking time after each PWM edge
  localparam int unsigned BLANK_NS        = 1000;   // 1 us
  localparam int unsigned BLANK_CYC       =
    (BLANK_NS * (REF_HZ / 1_000_000) + 999) / 1000;
  // Reset values
  localparam logic        RST_FLAG        = 1'b0;
  localparam logic [3:0]  RST_CNT         = 4'h0;
  // Speed-sensor input select code for encoder operation
  localparam logic [1:0]  INSEL_ENCODER   = 2'h3;
  localparam logic [1:0]  TES_OFF         = 2'h0;

  // Z sampling type
  typedef enum logic [1:0] {
    ZS_OFF_END   = 2'b00,  // End of off time, PWM rate
    ZS_FAST_FREE = 2'b01,  // Fast rate, independent of PWM
    ZS_ON_PWM    = 2'b10,  // One delayed sample in on time
    ZS_ON_FAST   = 2'b11   // Fast rate in on time after delay
  } bzs_ztype_type;

  // Detection phase
  typedef enum logic [1:0] {
    PH_D_WIN = 2'b00,
    PH_D_EVT = 2'b01,
    PH_Z_WIN = 2'b10,
    PH_Z_EVT = 2'b11
  } bzs_phase_type;
endpackage

// file: hw/bzs_sampler.sv
// Back-EMF comparator sampling scheduler with window and event filters
`timescale 1ns/10ps

module bzs_sampler
  import bzs_pkg::*;
#(
  parameter int unsigned STEP_CYC  = DELAY_STEP_CYC,
  parameter int unsigned BLANK_C   = BLANK_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       pwm_on_i,               // PWM level, pin domain
  input  wire logic       comp_i,                 // Phase comparator, pin
  input  wire logic       fast_tick_i,            // Fast sample enable pulse
  input  wire logic       c_event_i,              // Commutation pulse
  input  wire logic [3:0] sample_delay_sel_i,
  input  wire logic       high_rate_sampling_en_i,
  input  wire logic       sample_outside_irq_mask_i,
  input  wire logic       sample_outside_clr_i,   // Clears flag (pulse)
  input  wire logic       motor_output_enable_i,
  input  wire logic       sensor_mode_sel_i,      // 1: hall sensors
  input  wire logic       z_sampling_keep_i,
  input  wire logic       off_phase_discharge_sel_i,
  input  wire logic [3:0] d_window_filter_i,
  input  wire logic [3:0] d_event_filter_i,
  input  wire logic [3:0] z_window_filter_i,
  input  wire logic [3:0] z_event_filter_count_i,
  input  wire logic [1:0] tacho_edge_sel_i,
  input  wire logic [1:0] input_sel_i,
  output logic            sample_outside_flag_o,
  output logic            sample_outside_irq_o,
  output logic            min_off_zero_o,         // Min off time forced 0
  output logic            full_duty_ok_o,         // 100% duty permitted
  output logic            off_phase_ground_o,     // Ground off phases now
  output logic            d_event_o,              // D detected pulse
  output logic            z_event_o,              // Z detected pulse
  output logic            speed_sensor_mode_o,
  output logic            encoder_mode_o,
  output logic            tacho_mode_o
);

  // Counters are eight bits wide; refuse counts they cannot hold
  if (STEP_CYC < 1 || STEP_CYC > 255 ||
      BLANK_C < 1 || BLANK_C > 255) begin : g_bad_counts
    $error("bzs_sampler: counts out of range");
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] pwm_sync_r, pwm_sync_nxt;  // Three-stage PWM sync
  logic [2:0] cmp_sync_r, cmp_sync_nxt;  // Three-stage comparator sync
  logic       pwm_r, pwm_nxt;            // Accepted PWM level
  logic       cmp_r, cmp_nxt;            // Accepted comparator level

  // Change accepted once stages two and three agree
  always_comb begin
    pwm_sync_nxt = {pwm_sync_r[1:0], pwm_on_i};
    cmp_sync_nxt = {cmp_sync_r[1:0], comp_i};
    pwm_nxt      = (pwm_sync_r[1] == pwm_sync_r[2]) ? pwm_sync_r[2] : pwm_r;
    cmp_nxt      = (cmp_sync_r[1] == cmp_sync_r[2]) ? cmp_sync_r[2] : cmp_r;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pwm_sync_r <= 3'h0;
      cmp_sync_r <= 3'h0;
      pwm_r      <= 1'b0;
      cmp_r      <= 1'b0;
    end else begin
      pwm_sync_r <= pwm_sync_nxt;
      cmp_sync_r <= cmp_sync_nxt;
      pwm_r      <= pwm_nxt;
      cmp_r      <= cmp_nxt;
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic          delay_nz;   // Delay selector nonzero
  bzs_ztype_type ztype;      // Selected Z sampling type
  logic          pwm_rise;
  logic          pwm_fall;
  logic          pwm_d_r;    // Previous accepted PWM level

  always_comb begin
    delay_nz = (sample_delay_sel_i != 4'h0);
    ztype    = bzs_ztype_type'({delay_nz, high_rate_sampling_en_i});
    pwm_rise = pwm_r & ~pwm_d_r;
    pwm_fall = ~pwm_r & pwm_d_r;
  end

  // ****************************************************************
  // Delay timer and blanking timer
  // ****************************************************************
  logic [7:0] step_cnt_r, step_cnt_nxt;   // Cycles within one step
  logic [3:0] steps_r, steps_nxt;         // Steps remaining
  logic       dly_run_r, dly_run_nxt;     // Delay in progress
  logic       win_r, win_nxt;             // On-time sample window open
  logic [7:0] blank_r, blank_nxt;         // Blanking countdown
  logic       dly_done;                   // Delay expiry this cycle

  // Delay starts on each turn-on edge; expiry gives the sampling order
  always_comb begin
    step_cnt_nxt = step_cnt_r;
    steps_nxt    = steps_r;
    dly_run_nxt  = dly_run_r;
    win_nxt      = win_r;
    dly_done     = 1'b0;
    blank_nxt    = (blank_r != 8'h00) ? blank_r - 8'h01 : 8'h00;
    if (pwm_rise || pwm_fall) begin
      blank_nxt = 8'(BLANK_C);
    end
    if (pwm_rise && delay_nz) begin
      dly_run_nxt  = 1'b1;
      steps_nxt    = sample_delay_sel_i;
      step_cnt_nxt = 8'(STEP_CYC - 1);
      win_nxt      = 1'b0;
    end else if (dly_run_r) begin
      if (step_cnt_r != 8'h00) begin
        step_cnt_nxt = step_cnt_r - 8'h01;
      end else if (steps_r > 4'h1) begin
        steps_nxt    = steps_r - 4'h1;
        step_cnt_nxt = 8'(STEP_CYC - 1);
      end else begin
        dly_run_nxt = 1'b0;
        dly_done    = 1'b1;
        win_nxt     = (ztype == ZS_ON_FAST) && pwm_r;
      end
    end
    if (!pwm_r || !delay_nz) begin
      win_nxt = 1'b0;  // Window closes at the next off transition
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      step_cnt_r <= 8'h00;
      steps_r    <= RST_CNT;
      dly_run_r  <= 1'b0;
      win_r      <= 1'b0;
      blank_r    <= 8'h00;
      pwm_d_r    <= 1'b0;
    end else begin
      step_cnt_r <= step_cnt_nxt;
      steps_r    <= steps_nxt;
      dly_run_r  <= dly_run_nxt;
      win_r      <= win_nxt;
      blank_r    <= blank_nxt;
      pwm_d_r    <= pwm_r;
    end
  end

  // ****************************************************************
  // Sample scheduling and filters
  // ****************************************************************
  logic          d_take;       // D sample strobe
  logic          z_take;       // Z sample strobe
  logic          z_run;        // Z sampling allowed
  logic          outside;      // Delayed sample missed the on time
  bzs_phase_type ph_r, ph_nxt;
  logic [3:0]    cnt_r, cnt_nxt;
  logic          flag_r, flag_nxt;
  logic          d_ev_r, d_ev_nxt;
  logic          z_ev_r, z_ev_nxt;
  logic          z_match;      // Sample shows the expected Z level
  logic [3:0]    need;         // Count needed in present phase

  always_comb begin
    // Outputs disabled, sensorless, slow rate: keep bit decides Z
    z_run = !(!motor_output_enable_i && !sensor_mode_sel_i &&
              !high_rate_sampling_en_i) || z_sampling_keep_i;
    d_take = fast_tick_i && (blank_r == 8'h00);
    outside = dly_done && !pwm_r;
    z_take = 1'b0;
    if (sensor_mode_sel_i) begin
      z_take = fast_tick_i;
    end else begin
      unique case (ztype)
        ZS_OFF_END:   z_take = pwm_rise;  // Last off-time sample
        ZS_FAST_FREE: z_take = fast_tick_i && (blank_r == 8'h00);
        ZS_ON_PWM:    z_take = dly_done && pwm_r;
        ZS_ON_FAST:   z_take = (fast_tick_i && win_r) ||
                               (dly_done && pwm_r);
      endcase
    end
    z_take  = z_take && z_run;
    z_match = cmp_r;
    unique case (ph_r)
      PH_D_WIN: need = d_window_filter_i;
      PH_D_EVT: need = d_event_filter_i;
      PH_Z_WIN: need = z_window_filter_i;
      PH_Z_EVT: need = z_event_filter_count_i;
    endcase
    // Sample-outside flag: set wins over clear, only with a delay
    flag_nxt = flag_r;
    if (sample_outside_clr_i) begin
      flag_nxt = 1'b0;
    end
    if (outside && delay_nz) begin
      flag_nxt = 1'b1;
    end
    ph_nxt   = ph_r;
    cnt_nxt  = cnt_r;
    d_ev_nxt = 1'b0;
    z_ev_nxt = 1'b0;
    if (c_event_i && !sensor_mode_sel_i) begin
      ph_nxt  = PH_D_WIN;
      cnt_nxt = 4'h0;
    end else if (c_event_i) begin
      ph_nxt  = PH_Z_EVT;  // Sensor mode: only the Z event filter
      cnt_nxt = 4'h0;
    end else begin
      unique case (ph_r)
        PH_D_WIN: if (d_take) begin
          if (cnt_r >= need) begin
            ph_nxt = PH_D_EVT;
            cnt_nxt = 4'h0;
          end else cnt_nxt = cnt_r + 4'h1;
        end
        PH_D_EVT: if (d_take) begin
          if (!z_match) begin  // Demag over: comparator released
            if (cnt_r >= need) begin
              ph_nxt   = PH_Z_WIN;
              cnt_nxt  = 4'h0;
              d_ev_nxt = 1'b1;
            end else cnt_nxt = cnt_r + 4'h1;
          end else cnt_nxt = 4'h0;
        end
        PH_Z_WIN: if (z_take) begin
          if (cnt_r >= need) begin
            ph_nxt = PH_Z_EVT;
            cnt_nxt = 4'h0;
          end else cnt_nxt = cnt_r + 4'h1;
        end
        PH_Z_EVT: if (z_take) begin
          if (z_match) begin
            if (cnt_r >= need) begin
              z_ev_nxt = (cnt_r == need);
              cnt_nxt  = 4'hF;  // Hold until a mismatching sample or next commutation
            end else cnt_nxt = cnt_r + 4'h1;
          end else cnt_nxt = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ph_r   <= PH_D_WIN;
      cnt_r  <= RST_CNT;
      flag_r <= RST_FLAG;
      d_ev_r <= 1'b0;
      z_ev_r <= 1'b0;
    end else begin
      ph_r   <= ph_nxt;
      cnt_r  <= cnt_nxt;
      flag_r <= flag_nxt;
      d_ev_r <= d_ev_nxt;
      z_ev_r <= z_ev_nxt;
    end
  end

  // ****************************************************************
  // Registered status and control outputs
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sample_outside_flag_o <= 1'b0;
      sample_outside_irq_o  <= 1'b0;
      min_off_zero_o        <= 1'b0;
      full_duty_ok_o        <= 1'b0;
      off_phase_ground_o    <= 1'b0;
      d_event_o             <= 1'b0;
      z_event_o             <= 1'b0;
      speed_sensor_mode_o   <= 1'b0;
      encoder_mode_o        <= 1'b0;
      tacho_mode_o          <= 1'b0;
    end else begin
      sample_outside_flag_o <= flag_r;
      // Interrupt gated by delay so zero delay never raises it
      sample_outside_irq_o  <= flag_r && sample_outside_irq_mask_i &&
                               delay_nz;
      // Any delay, or fast rate, removes the minimum off time
      min_off_zero_o        <= delay_nz || high_rate_sampling_en_i ||
                               sensor_mode_sel_i;
      full_duty_ok_o        <= delay_nz || high_rate_sampling_en_i ||
                               sensor_mode_sel_i;
      // Grounding only matters during end-of-off-time sampling
      off_phase_ground_o    <= off_phase_discharge_sel_i &&
                               !sensor_mode_sel_i &&
                               (ztype == ZS_OFF_END) && !pwm_r;
      d_event_o             <= d_ev_r;
      z_event_o             <= z_ev_r;
      speed_sensor_mode_o   <= (tacho_edge_sel_i != TES_OFF);
      encoder_mode_o        <= (tacho_edge_sel_i != TES_OFF) &&
                               (input_sel_i == INSEL_ENCODER);
      tacho_mode_o          <= (tacho_edge_sel_i != TES_OFF) &&
                               (input_sel_i != INSEL_ENCODER);
    end
  end

endmodule // bzs_sampler

// file: verif/bzs_inverter_model.sv
// Partner: PWM generator, inverter feedback and phase comparator
`timescale 1ns/10ps
// ****************************************
// Inverter model
// ****************************************
module bzs_inverter_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] per_i,       // PWM period in cycles
  input  wire logic [7:0] on_i,        // PWM on time in cycles
  input  wire logic       comp_lvl_i,  // Back-EMF comparator level
  output logic            pwm_on_o,
  output logic            comp_o,
  output logic            fast_tick_o
);
  logic [7:0] cnt_r;  // Position inside the PWM period
  // Free-running PWM; the fast tick comes every fourth count of its counter
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || cnt_r >= per_i - 8'h01) cnt_r <= 8'h00;
    else cnt_r <= cnt_r + 8'h01;
    pwm_on_o    <= rst_b_i && (cnt_r < on_i);
    fast_tick_o <= (cnt_r[1:0] == 2'h3);
    comp_o      <= comp_lvl_i;
  end
endmodule // bzs_inverter_model

// file: verif/bzs_sampler_props.sv
// Checker: port-level properties of the back-EMF sampler
`timescale 1ns/10ps
// ****************************************
// Checker module
// ****************************************
module bzs_sampler_props
  import bzs_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic [3:0] sample_delay_sel_i,
  input wire logic       sample_outside_irq_mask_i,
  input wire logic       sample_outside_clr_i,
  input wire logic       off_phase_discharge_sel_i,
  input wire logic [1:0] tacho_edge_sel_i,
  input wire logic [1:0] input_sel_i,
  input wire logic       sample_outside_flag_o,
  input wire logic       sample_outside_irq_o,
  input wire logic       min_off_zero_o,
  input wire logic       full_duty_ok_o,
  input wire logic       off_phase_ground_o,
  input wire logic       d_event_o,
  input wire logic       z_event_o,
  input wire logic       speed_sensor_mode_o,
  input wire logic       encoder_mode_o,
  input wire logic       tacho_mode_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Request only while flag stands and the mask was set
  irq_needs_flag_a: assert property (sample_outside_irq_o |->
    sample_outside_flag_o && $past(sample_outside_irq_mask_i))
    else $error("irq without flag and mask");
  irq_zero_dly_a: assert property ((sample_delay_sel_i == 4'h0) ##1
    (sample_delay_sel_i == 4'h0) |-> !sample_outside_irq_o)
    else $error("irq with zero delay");
  min_off_a: assert property ((sample_delay_sel_i != 4'h0) ##1
    (sample_delay_sel_i != 4'h0) |-> min_off_zero_o)
    else $error("min off time not zero");
  duty_match_a: assert property (full_duty_ok_o == min_off_zero_o)
    else $error("full duty differs from min off");
  speed_mode_a: assert property (1'b1 |=> speed_sensor_mode_o ==
    ($past(tacho_edge_sel_i) != TES_OFF)) else $error("speed mode wrong");
  encoder_mode_a: assert property (1'b1 |=> encoder_mode_o ==
    (($past(tacho_edge_sel_i) != TES_OFF) &&
     ($past(input_sel_i) == INSEL_ENCODER))) else $error("encoder wrong");
  tacho_mode_a: assert property (1'b1 |=> tacho_mode_o ==
    (($past(tacho_edge_sel_i) != TES_OFF) &&
     ($past(input_sel_i) != INSEL_ENCODER))) else $error("tacho wrong");
  // Flag only drops after a clear pulse
  flag_hold_a: assert property ($fell(sample_outside_flag_o) |->
    ($past(sample_outside_clr_i) || $past(sample_outside_clr_i, 2) ||
     $past(sample_outside_clr_i, 3))) else $error("flag dropped alone");
  no_flag_zero_a: assert property ($rose(sample_outside_flag_o) |->
    $past(sample_delay_sel_i, 2) != 4'h0) else $error("flag with zero delay");
  d_pulse_a: assert property (d_event_o |=> !d_event_o)
    else $error("d event not a pulse");
  z_pulse_a: assert property (z_event_o |=> !z_event_o)
    else $error("z event not a pulse");
  ground_sel_a: assert property (off_phase_ground_o |->
    $past(off_phase_discharge_sel_i)) else $error("ground not selected");
  d_cov: cover property (d_event_o);
  z_cov: cover property (z_event_o);
  irq_cov: cover property (sample_outside_irq_o);
endmodule // bzs_sampler_props

bind bzs_sampler bzs_sampler_props u_props (.*);

// file: verif/bzs_sampler_test.sv
// Testbench: scenarios for the back-EMF sampler
`timescale 1ns/10ps
module bzs_sampler_test;
  import bzs_pkg::*;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, pwm_on, comp, tick, c_ev = 1'b0;
  logic [3:0] dly = 4'h0, filt = 4'h2;
  logic spl = 1'b0, mask = 1'b0, clr = 1'b0, motor_output_enable = 1'b1, off_phase_discharge_sel = 1'b0;
  logic sens = 1'b0, keep = 1'b0, gseen;
  logic [2:0] mexp;
  logic [1:0] tes = 2'h0, insel = 2'h0;
  logic [7:0] per = 8'h28, on = 8'h14;
  logic lvl = 1'b0, seen;
  logic flag, irq, mo, fd, gnd, d_ev, z_ev, spd, enc, tac;
  int miscompares = 0, compares = 0;
  initial forever #25 mclk_i = ~mclk_i;
  bzs_inverter_model u_inv (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .per_i(per), .on_i(on), .comp_lvl_i(lvl), .pwm_on_o(pwm_on),
    .comp_o(comp), .fast_tick_o(tick));
  bzs_sampler #(.STEP_CYC(2), .BLANK_C(2)) uut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .pwm_on_i(pwm_on),
    .comp_i(comp), .fast_tick_i(tick), .c_event_i(c_ev),
    .sample_delay_sel_i(dly), .high_rate_sampling_en_i(spl),
    .sample_outside_irq_mask_i(mask), .sample_outside_clr_i(clr),
    .motor_output_enable_i(motor_output_enable), .sensor_mode_sel_i(sens),
    .z_sampling_keep_i(keep), .off_phase_discharge_sel_i(off_phase_discharge_sel),
    .d_window_filter_i(filt), .d_event_filter_i(filt),
    .z_window_filter_i(filt), .z_event_filter_count_i(filt),
    .tacho_edge_sel_i(tes), .input_sel_i(insel),
    .sample_outside_flag_o(flag), .sample_outside_irq_o(irq),
    .min_off_zero_o(mo), .full_duty_ok_o(fd), .off_phase_ground_o(gnd),
    .d_event_o(d_ev), .z_event_o(z_ev), .speed_sensor_mode_o(spd),
    .encoder_mode_o(enc), .tacho_mode_o(tac));
  // Compare and count
  task automatic chk(string what, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Bounded wait for one event pulse
  task automatic wait_ev(bit z, int n);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      cyc(1);
      seen = z ? (z_ev === 1'b1) : (d_ev === 1'b1);
    end
  endtask
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Expected speed-sensor decode
  function automatic logic [2:0] mode_exp(logic [1:0] t, logic [1:0] s);
    return {t != 2'h0, t != 2'h0 && s == 2'h3, t != 2'h0 && s != 2'h3};
  endfunction
  // Z type table: high rate, delay, outputs on, Z keep bit
  logic spl_t [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [3:0] dly_t [6] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h0, 4'h0};
  logic moe_t [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic keep_t [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  initial begin
    #(50 * 60000);
    miscompares++;
    final_report();
  end
  initial begin
    void'($urandom(92684));
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    cyc(4);
    // Every tacho edge and input select code
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk_i) {tes, insel} <= 4'(i);
      cyc(2);
      mexp = mode_exp(tes, insel);
      chk("speed", mexp[2], spd);
      chk("encoder", mexp[1], enc);
      chk("tacho", mexp[0], tac);
    end
    // Random nonzero delays force zero min off time and full duty
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_i) dly <= 4'($urandom_range(15, 1));
      spl <= 1'($urandom);
      cyc(3);
      chk("min_off", 1'b1, mo);
      chk("full_duty", 1'b1, fd);
    end
    // Short delay inside on time leaves flag clear; clear only once the
    // delays begun under the random settings have run out (set wins)
    @(posedge mclk_i) begin dly <= 4'h1; spl <= 1'b0; end
    cyc(100);
    @(posedge mclk_i) clr <= 1'b1;
    @(posedge mclk_i) clr <= 1'b0;
    cyc(200);
    chk("flag_in", 1'b0, flag);
    // Delay longer than on time, high rate and slow
    @(posedge mclk_i) begin dly <= 4'hF; on <= 8'h06; mask <= 1'b1; end
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i) spl <= 1'(k);
      cyc(200);
      chk("flag_out", 1'b1, flag);
      chk("irq", 1'b1, irq);
      // Flag stands with zero delay, but the request must drop
      @(posedge mclk_i) dly <= 4'h0;
      cyc(4);
      chk("flag_hold", 1'b1, flag);
      chk("irq_zero", 1'b0, irq);
      @(posedge mclk_i) clr <= 1'b1;
      @(posedge mclk_i) clr <= 1'b0;
      cyc(4);
      chk("flag_clr", 1'b0, flag);
      @(posedge mclk_i) dly <= 4'hF;
    end
    @(posedge mclk_i) begin mask <= 1'b0; dly <= 4'h0; on <= 8'h14; end
    // All Z sampling types and the stopped Z case
    for (int r = 0; r < 6; r++) begin
      @(posedge mclk_i) begin spl <= spl_t[r]; dly <= dly_t[r]; end
      motor_output_enable <= moe_t[r];
      keep <= keep_t[r];
      off_phase_discharge_sel <= ~1'(r);
      lvl <= 1'b0;
      cyc(8);
      // Grounding shows only in end-of-off-time sampling when selected
      gseen = 1'b0;
      repeat (40) begin
        cyc(1);
        gseen = gseen | gnd;
      end
      chk("ground", ~1'(r) & ~spl_t[r] & (dly_t[r] == 4'h0), gseen);
      @(posedge mclk_i) c_ev <= 1'b1;
      @(posedge mclk_i) c_ev <= 1'b0;
      wait_ev(1'b0, 400);
      chk("d_event", 1'b1, seen);
      @(posedge mclk_i) lvl <= 1'b1;
      wait_ev(1'b1, 400);
      chk("z_event", moe_t[r] | keep_t[r], seen);
      wait_ev(1'b1, 300);
      chk("z_once", 1'b0, seen);
    end
    // Hall sensor mode: commutation leads straight to the Z event filter
    @(posedge mclk_i) sens <= 1'b1;
    cyc(4);
    @(posedge mclk_i) c_ev <= 1'b1;
    @(posedge mclk_i) c_ev <= 1'b0;
    wait_ev(1'b1, 100);
    chk("z_sensor", 1'b1, seen);
    final_report();
  end
endmodule // bzs_sampler_test
